//--- flashlight_ctrl.sv
// Purpose: single lamp controller, modes, battery watch, drive pulse
// Assumes: BUTTON already clean and synchronous
// Notes: nonvolatile map is an array that reset leaves untouched
`timescale 1ns/10ps
`default_nettype none
`include "flash_defs.svh"

module flashlight_ctrl #(
   parameter logic [15:0] HOLD_PASSES = 16'(`HOLD_PASSES),
   parameter logic [11:0] BLINK_PASSES = 12'(`BLINK_PASSES),
   parameter logic [12:0] ADC_SKIP = 13'(`ADC_SKIP),
   parameter logic [6:0] SEQ_SKIP = 7'(`SEQ_SKIP)
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic BUTTON,
   output logic ADC_START,
   input wire logic ADC_DONE,
   input wire logic [7:0] ADC_RESULT,
   output logic DRIVE_REF,
   output logic [2:0] MODE,
   output logic SEQ_RUN,
   output logic SEQ_STEP,
   output logic [7:0] SEQ_START,
   input wire logic [5:0] SEQ_LEVEL,
   input wire logic [11:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [11:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   logic [7:0] nv [0:127];
   logic [7:0] tick_timer;
   logic tick_rollover_flag;
   logic short_high;
   logic [7:0] pwm_cnt;
   logic pwm_out;
   logic [2:0] key_skip;
   logic [12:0] adc_skip;
   logic [6:0] seq_skip;
   logic key_run, adc_run, seq_tick;
   flash_pkg::key_state_t key_state;
   logic [15:0] hold_cnt;
   logic hold_evt, rel_evt;
   logic booted, changing;
   logic [3:0] intensity;
   logic [2:0] blink_left;
   logic blink_on;
   logic [11:0] blink_tmr;
   flash_pkg::adc_state_t adc_state;
   logic [3:0] bias_cnt;
   logic [7:0] adc_res, comp, low_code;
   logic adc_done_evt;
   logic [4:0] low_run;
   logic sleeping, low_flag;
   logic [5:0] level, prev_level;
   logic [7:0] duty;
   logic aw_got, w_got;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire, wr_ctrl, wr_nv, commit;
   logic [31:0] next_rdata;

   // product saturates; larger comp lifts the duty as supply sags
   function automatic logic [7:0] scale(input logic [5:0] lv, input logic [7:0] k);
      logic [13:0] p;
      p = {8'h00, lv} * {6'h00, k};
      return p[13] ? 8'hff : p[12:5];
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return a == `REG_CONTROL || a == `REG_STATUS || a == `REG_LOW_CODE ||
         (a >= `NV_WIN && a < `NV_WIN + 12'h200);
   endfunction

   function automatic logic [2:0] valid_mode(input logic [7:0] v);
      return (v >= 8'h01 && v <= 8'(`MODE_MAX)) ? v[2:0] : 3'h1;
   endfunction

   // window offset removed so the first map word is byte 0
   function automatic logic [6:0] nv_index(input logic [11:0] a);
      logic [11:0] off;
      off = a - `NV_WIN;
      return off[8:2];
   endfunction

   // tick timer and its rollover flag; set wins over the clear
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tick_timer <= 8'h00;
         tick_rollover_flag <= 1'b0;
      end else begin
         tick_timer <= tick_timer + 8'h01;
         if (tick_timer == 8'hff) begin
            tick_rollover_flag <= 1'b1;
         end else if (tick_rollover_flag) begin
            tick_rollover_flag <= 1'b0;
         end
      end
   end

   // drive pulse: reloaded on each rollover pass
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         short_high <= 1'b1;
         pwm_cnt <= 8'h00;
      end else if (tick_rollover_flag) begin
         short_high <= duty < 8'h80;
         pwm_cnt <= (duty < 8'h80) ? duty : 8'h00 - duty;
      end else if (short_high && pwm_cnt != 8'h00) begin
         pwm_cnt <= pwm_cnt - 8'h01;
      end
   end

   // long pulses time only the low tail at the end of the period
   assign pwm_out = short_high ? (pwm_cnt != 8'h00) : (~tick_timer >= pwm_cnt);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         DRIVE_REF <= 1'b0;
      end else begin
         DRIVE_REF <= !sleeping && (adc_state != flash_pkg::ADC_IDLE || pwm_out);
      end
   end

   // skip timers; offsets mean at most one expires per pass
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         key_skip <= `KEY_RST;
         adc_skip <= `ADC_RST;
         seq_skip <= `SEQ_RST;
         key_run <= 1'b0;
         adc_run <= 1'b0;
         seq_tick <= 1'b0;
      end else begin
         key_run <= 1'b0;
         adc_run <= 1'b0;
         seq_tick <= 1'b0;
         if (tick_rollover_flag) begin
            if (key_skip == 3'h1) begin
               key_skip <= `KEY_SKIP;
               key_run <= 1'b1;
            end else begin
               key_skip <= key_skip - 3'h1;
            end
            if (adc_skip == 13'h0001) begin
               adc_skip <= ADC_SKIP;
               adc_run <= 1'b1;
            end else begin
               adc_skip <= adc_skip - 13'h0001;
            end
            if (seq_skip == 7'h01) begin
               seq_skip <= SEQ_SKIP;
               seq_tick <= 1'b1;
            end else begin
               seq_skip <= seq_skip - 7'h01;
            end
         end
      end
   end

   assign SEQ_STEP = seq_tick && SEQ_RUN && !sleeping;

   // button timing; wake press is swallowed until release
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         key_state <= flash_pkg::KEY_IDLE;
         hold_cnt <= 16'h0000;
         hold_evt <= 1'b0;
         rel_evt <= 1'b0;
      end else begin
         hold_evt <= 1'b0;
         rel_evt <= 1'b0;
         if (sleeping) begin
            key_state <= flash_pkg::KEY_BLOCK;
         end else if (key_run) begin
            case (key_state)
               flash_pkg::KEY_IDLE: begin
                  if (BUTTON) begin
                     key_state <= flash_pkg::KEY_HELD;
                     hold_cnt <= 16'h0000;
                  end
               end
               flash_pkg::KEY_HELD: begin
                  if (!BUTTON) begin
                     key_state <= flash_pkg::KEY_IDLE;
                     rel_evt <= 1'b1;
                  end else if (hold_cnt == HOLD_PASSES - 16'h0001) begin
                     hold_cnt <= 16'h0000;
                     hold_evt <= 1'b1;
                  end else begin
                     hold_cnt <= hold_cnt + 16'h0001;
                  end
               end
               flash_pkg::KEY_BLOCK: begin
                  if (!BUTTON) begin
                     key_state <= flash_pkg::KEY_IDLE;
                  end
               end
               default: key_state <= flash_pkg::KEY_IDLE;
            endcase
         end
      end
   end

   logic [2:0] MODE_q;
   assign commit = rel_evt && changing;
   assign MODE = MODE_q;

   // mode selection; resumes stored mode right after reset
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         booted <= 1'b0;
         MODE_q <= 3'h1;
         changing <= 1'b0;
         SEQ_RUN <= 1'b0;
         intensity <= 4'h0;
      end else if (!booted) begin
         booted <= 1'b1;
         MODE_q <= valid_mode(nv[`NV_MODE]);
         intensity <= nv[`NV_INTENSITY][3:0];
         SEQ_RUN <= valid_mode(nv[`NV_MODE]) != 3'h1;
      end else begin
         if (hold_evt) begin
            changing <= 1'b1;
            SEQ_RUN <= 1'b0;
            MODE_q <= (MODE_q >= `MODE_MAX) ? 3'h1 : MODE_q + 3'h1;
         end else if (commit) begin
            changing <= 1'b0;
            SEQ_RUN <= MODE_q != 3'h1;
         end
         if (wr_ctrl) begin
            intensity <= w_data[3:0];
         end
      end
   end

   // blink count: off gap, then on, repeated as many times as the new mode number
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         blink_left <= 3'h0;
         blink_on <= 1'b0;
         blink_tmr <= 12'h000;
      end else if (hold_evt) begin
         blink_left <= (MODE_q >= `MODE_MAX) ? 3'h1 : MODE_q + 3'h1;
         blink_on <= 1'b0;
         blink_tmr <= BLINK_PASSES - 12'h001;
      end else if (key_run && blink_left != 3'h0) begin
         if (blink_tmr != 12'h000) begin
            blink_tmr <= blink_tmr - 12'h001;
         end else begin
            blink_tmr <= BLINK_PASSES - 12'h001;
            blink_on <= !blink_on;
            if (blink_on) begin
               blink_left <= blink_left - 3'h1;
            end
         end
      end
   end

   always_comb begin
      if (changing) begin
         level = blink_on ? 6'h3f : 6'h00;
      end else if (MODE_q == 3'h1) begin
         level = {intensity, intensity[3:2]};
      end else begin
         level = SEQ_LEVEL;
      end
   end

   // duty recomputed on new sample or any level change
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         prev_level <= 6'h00;
         duty <= 8'h00;
      end else begin
         prev_level <= level;
         if (level != prev_level || adc_done_evt) begin
            duty <= scale(level, comp);
         end
      end
   end

   // battery sample: bias the diode first, then convert
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         adc_state <= flash_pkg::ADC_IDLE;
         bias_cnt <= 4'h0;
         ADC_START <= 1'b0;
         adc_res <= 8'h00;
         comp <= `COMP_RST;
         adc_done_evt <= 1'b0;
      end else begin
         ADC_START <= 1'b0;
         adc_done_evt <= 1'b0;
         case (adc_state)
            flash_pkg::ADC_IDLE: begin
               if (adc_run && !sleeping) begin
                  adc_state <= flash_pkg::ADC_BIAS;
                  bias_cnt <= `BIAS_CLKS - 4'h1;
               end
            end
            flash_pkg::ADC_BIAS: begin
               if (sleeping) begin
                  adc_state <= flash_pkg::ADC_IDLE;
               end else if (bias_cnt == 4'h0) begin
                  ADC_START <= 1'b1;
                  adc_state <= flash_pkg::ADC_CONV;
               end else begin
                  bias_cnt <= bias_cnt - 4'h1;
               end
            end
            flash_pkg::ADC_CONV: begin
               if (ADC_DONE) begin
                  adc_res <= ADC_RESULT;
                  comp <= ADC_RESULT;
                  adc_done_evt <= 1'b1;
                  adc_state <= flash_pkg::ADC_IDLE;
               end
            end
            default: adc_state <= flash_pkg::ADC_IDLE;
         endcase
      end
   end

   // power state and low-supply run
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sleeping <= 1'b0;
         low_flag <= 1'b0;
         low_run <= 5'h00;
      end else begin
         if (sleeping) begin
            if (BUTTON) begin
               sleeping <= 1'b0;
               low_flag <= 1'b0;
            end
         end else if (adc_done_evt) begin
            if (adc_res > low_code) begin
               if (low_run == 5'(`LOW_RUN - 6'h01)) begin
                  sleeping <= 1'b1;
                  low_flag <= 1'b1;
                  low_run <= 5'h00;
               end else begin
                  low_run <= low_run + 5'h01;
               end
            end else begin
               low_run <= 5'h00;
            end
         end
         if (wr_ctrl && w_data[`CTL_SLEEP]) begin
            sleeping <= 1'b1;
         end
      end
   end

   // nonvolatile map; no reset so contents survive power-off
   always_ff @(posedge CLOCK) begin
      if (commit) begin
         nv[`NV_MODE] <= {5'h00, MODE_q};
      end
      if (wr_nv) begin
         nv[nv_index(aw_addr)] <= w_data[7:0];
      end
      if (MODE_q >= 3'h2) begin
         SEQ_START <= nv[`NV_SEQ_BASE + {4'h0, MODE_q} - 7'h02];
      end else begin
         SEQ_START <= 8'h00;
      end
   end

   // register slave
   assign AWREADY = !aw_got && !BVALID;
   assign WREADY = !w_got && !BVALID;
   assign ARREADY = !RVALID;
   assign wr_fire = aw_got && w_got;
   assign wr_ctrl = wr_fire && aw_addr == `REG_CONTROL && w_strb[0];
   assign wr_nv = wr_fire && aw_addr >= `NV_WIN && aw_addr < `NV_WIN + 12'h200 && w_strb[0];

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= 2'b00;
         low_code <= `LOW_CODE_RST;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_got <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_got <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (wr_fire) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= mapped(aw_addr) ? 2'b00 : 2'b10;
            if (aw_addr == `REG_LOW_CODE && w_strb[0]) begin
               low_code <= w_data[7:0];
            end
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   always_comb begin
      next_rdata = 32'h00000000;
      if (ARADDR == `REG_CONTROL) begin
         next_rdata[3:0] = intensity;
      end else if (ARADDR == `REG_STATUS) begin
         next_rdata[2:0] = MODE_q;
         next_rdata[`ST_SLEEP] = sleeping;
         next_rdata[`ST_LOW] = low_flag;
         next_rdata[`ST_CHG] = changing;
         next_rdata[`ST_RUN] = SEQ_RUN;
         next_rdata[`ST_DUTY_LSB +: 8] = duty;
         next_rdata[`ST_COMP_LSB +: 8] = comp;
      end else if (ARADDR == `REG_LOW_CODE) begin
         next_rdata[7:0] = low_code;
      end else if (mapped(ARADDR)) begin
         next_rdata[7:0] = nv[nv_index(ARADDR)];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= 2'b00;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RDATA <= next_rdata;
         RRESP <= mapped(ARADDR) ? 2'b00 : 2'b10;
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
      end
   end

   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);

   rollover_flag_a: assert property (tick_timer == 8'hff |=> tick_rollover_flag ##1 !tick_rollover_flag)
      else $error("rollover flag not set then cleared");
   drive_off_a: assert property (sleeping && $past(sleeping) |-> !DRIVE_REF)
      else $error("drive active while powered down");
   diode_bias_a: assert property (ADC_START |-> DRIVE_REF ##1 DRIVE_REF)
      else $error("drive low during conversion start");
   mode_wrap_a: assert property (booted && hold_evt && MODE_q == 3'h5 |=> MODE_q == 3'h1 && changing)
      else $error("mode did not wrap to one");
   mode_step_a: assert property (booted && hold_evt && MODE_q < 3'h5 |=> MODE_q == $past(MODE_q) + 3'h1)
      else $error("mode did not advance by one");
   low_shutdown_a: assert property (adc_done_evt && !sleeping && adc_res > low_code && low_run == 5'h1f |=> sleeping)
      else $error("no shutdown after low run");
   low_clear_a: assert property (adc_done_evt && !sleeping && adc_res <= low_code |=> low_run == 5'h00)
      else $error("low run not cleared by good sample");
   skip_apart_a: assert property ($onehot0({key_run, adc_run, seq_tick}))
      else $error("two skip timers expired together");
   release_keep_a: assert property (commit |=> !changing && SEQ_RUN == (MODE_q != 3'h1) && $stable(MODE_q))
      else $error("release did not settle the mode");
   pulse_start_a: assert property (tick_rollover_flag && duty != 8'h00 && !sleeping |=> ##1 DRIVE_REF)
      else $error("drive pulse did not start at rollover");

   hold_seen_c: cover property (hold_evt ##[1:8] hold_evt);
   wrap_seen_c: cover property (hold_evt && MODE_q == 3'h5);
   shutdown_seen_c: cover property (!sleeping ##1 sleeping && low_flag);
   sample_seen_c: cover property (adc_done_evt);
endmodule
`default_nettype wire

//--- flash_defs.svh
// Purpose: constants for the lamp controller
// Assumes: 20 MHz system clock
// Notes: times are kept in their own unit, counts derive from them
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH
`define CLK_HZ 20000000
`define TICK_CLKS 256
`define SKIP_BASE 5
`define PASS_CLKS (`TICK_CLKS * `SKIP_BASE)
`define HOLD_MS 3000
`define HOLD_PASSES ((`HOLD_MS * (`CLK_HZ / 1000)) / `PASS_CLKS)
`define BLINK_MS 250
`define BLINK_PASSES ((`BLINK_MS * (`CLK_HZ / 1000)) / `PASS_CLKS)
`define SAMPLE_HZ 10
`define ADC_SKIP (`SKIP_BASE * ((`CLK_HZ / `SAMPLE_HZ) / `PASS_CLKS))
`define SEQ_SKIP (`SKIP_BASE * 20)
`define KEY_SKIP 3'h5
`define KEY_RST 3'h5
`define ADC_RST 13'h0004
`define SEQ_RST 7'h03
`define BIAS_NS 400
`define BIAS_CLKS 4'((`BIAS_NS * (`CLK_HZ / 1000000)) / 1000)
`define LOW_RUN 6'h20
`define LOW_CODE_RST 8'hc0
`define COMP_RST 8'h80
`define MODE_MAX 3'h5
`define NV_INTENSITY 7'h00
`define NV_MODE 7'h01
`define NV_NMODES 7'h02
`define NV_SEQ_BASE 7'h03
`define NV_SEQ1 7'h07
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_LOW_CODE 12'h008
`define NV_WIN 12'h100
`define CTL_SLEEP 4
`define ST_SLEEP 4
`define ST_LOW 5
`define ST_CHG 6
`define ST_RUN 7
`define ST_DUTY_LSB 8
`define ST_COMP_LSB 16
`endif

//--- flash_pkg.sv
// Purpose: state types for the lamp controller
// Assumes: nothing
// Notes: codes written out
package flash_pkg;
   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_HELD = 2'b01,
      KEY_BLOCK = 2'b10
   } key_state_t;
   typedef enum logic [1:0] {
      ADC_IDLE = 2'b00,
      ADC_BIAS = 2'b01,
      ADC_CONV = 2'b10
   } adc_state_t;
endpackage

//--- sense_model.sv
// Purpose: battery sense converter model seen by the lamp controller
// Assumes: one conversion at a time, answer after 1 or 6 cycles
// Notes: idle result line flips so a stale value never looks valid
`timescale 1ns/10ps
`default_nettype none
module sense_model (
   input wire logic CLOCK,
   input wire logic ADC_START,
   input wire logic DRIVE_REF,
   input wire logic [7:0] code,
   input wire logic slow,
   output logic ADC_DONE,
   output logic [7:0] ADC_RESULT
);
   int wait_cnt = 0;
   logic biased = 1'b0;
   initial ADC_DONE = 1'b0;
   initial ADC_RESULT = 8'h00;
   always @(posedge CLOCK) begin
      ADC_DONE <= 1'b0;
      if (ADC_DONE) ADC_RESULT <= ~ADC_RESULT;
      if (ADC_START) begin
         wait_cnt <= slow ? 6 : 1;
         biased <= DRIVE_REF;
      end else if (wait_cnt == 1) begin
         wait_cnt <= 0;
         ADC_DONE <= 1'b1;
         // an unbiased diode reads as a healthy supply
         ADC_RESULT <= biased ? code : 8'h00;
      end else if (wait_cnt > 1) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
endmodule
`default_nettype wire

//--- tb_flashlight_ctrl.sv
// Purpose: self-checking bench for the lamp controller
// Assumes: short pass counts keep the run brief
// Notes: map bytes are written over the bus before they are relied on
`timescale 1ns/10ps
`default_nettype none
`include "flash_defs.svh"
module tb_flashlight_ctrl;
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [1:0] resp;} row_t;
   logic CLOCK, RST, BUTTON, ADC_START, ADC_DONE, DRIVE_REF, SEQ_RUN, slow;
   logic SEQ_STEP;
   logic [3:0] strb;
   logic [5:0] seq_level;
   logic [2:0] MODE;
   logic [7:0] ADC_RESULT, SEQ_START, code;
   logic [11:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, rd;
   logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
   logic [1:0] BRESP, RRESP, rs;
   int bad_count, check_count, t1, t2, i, last;
   int cyc = 0;
   row_t rows [11];
   flashlight_ctrl #(.HOLD_PASSES(16'h0004), .BLINK_PASSES(12'h002), .ADC_SKIP(13'h0005),
      .SEQ_SKIP(7'h0a)) u_flashlight_ctrl (.CLOCK(CLOCK), .RST(RST), .BUTTON(BUTTON),
      .ADC_START(ADC_START), .ADC_DONE(ADC_DONE), .ADC_RESULT(ADC_RESULT),
      .DRIVE_REF(DRIVE_REF), .MODE(MODE), .SEQ_RUN(SEQ_RUN), .SEQ_STEP(SEQ_STEP),
      .SEQ_START(SEQ_START), .SEQ_LEVEL(seq_level), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(strb), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
   sense_model u_sense_model (.CLOCK(CLOCK), .ADC_START(ADC_START), .DRIVE_REF(DRIVE_REF),
      .code(code), .slow(slow), .ADC_DONE(ADC_DONE), .ADC_RESULT(ADC_RESULT));
   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) cyc <= cyc + 1;
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic fail;
      bad_count++;
      $display("FAIL t=%0t wait ran out", $time);
      close_out();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      logic aw, w, b;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      b = 1'b0;
      for (k = 0; k < 40 && !b; k++) begin
         @(negedge CLOCK);
         aw = AWVALID && AWREADY;
         w = WVALID && WREADY;
         b = BVALID === 1'b1;
         r = BRESP;
         @(posedge CLOCK);
         if (aw) AWVALID <= 1'b0;
         if (w) WVALID <= 1'b0;
      end
      BREADY <= 1'b0;
      if (!b) fail();
      @(posedge CLOCK);
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      logic ar, got;
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      got = 1'b0;
      for (k = 0; k < 40 && !got; k++) begin
         @(negedge CLOCK);
         ar = ARVALID && ARREADY;
         got = RVALID === 1'b1;
         d = RDATA;
         r = RRESP;
         @(posedge CLOCK);
         if (ar) ARVALID <= 1'b0;
      end
      RREADY <= 1'b0;
      if (!got) fail();
      @(posedge CLOCK);
   endtask
   task automatic do_reset;
      RST <= 1'b1;
      repeat (4) @(posedge CLOCK);
      RST <= 1'b0;
   endtask
   task automatic wait_mode(input logic [2:0] m, output int t);
      int k;
      for (k = 0; k < 20000 && MODE !== m; k++) @(negedge CLOCK);
      if (MODE !== m) fail();
      t = cyc;
   endtask
   // samples must arrive a fixed number of rollovers apart
   task automatic samples(input int n);
      int k, got;
      got = 0;
      for (k = 0; k < 3000 * n && got < n; k++) begin
         @(negedge CLOCK);
         if (ADC_START === 1'b1) begin
            got++;
            check({31'h0, DRIVE_REF}, 32'h1);
            if (last != 0) check(cyc - last, 1280);
            last = cyc;
         end
      end
      if (got < n) fail();
      repeat (20) @(posedge CLOCK);
   endtask
   // window starts 300 cycles after a sample, past the next reload, so every reload in it uses the new duty
   task automatic duty_run(input int want);
      int k, n;
      n = 0;
      for (k = 0; k < 3000 && ADC_START !== 1'b1; k++) @(negedge CLOCK);
      if (ADC_START !== 1'b1) fail();
      last = cyc;
      repeat (300) @(negedge CLOCK);
      for (k = 0; k < 256; k++) begin
         @(negedge CLOCK);
         if (DRIVE_REF === 1'b1) n++;
      end
      check(n, want);
      @(posedge CLOCK);
   endtask
   initial begin
      bad_count = 0;
      check_count = 0;
      last = 0;
      strb = 4'hf;
      seq_level = 6'h3f;
      RST = 1'b1;
      BUTTON = 1'b0;
      code = 8'h10;
      slow = 1'b0;
      {AWADDR, ARADDR, WDATA} = '0;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      rows = '{'{0, `REG_LOW_CODE, 32'hc0, 2'b00}, '{1, `REG_CONTROL, 32'h0f, 2'b00},
         '{0, `REG_CONTROL, 32'h0f, 2'b00}, '{1, 12'h104, 32'h05, 2'b00},
         '{0, 12'h104, 32'h05, 2'b00}, '{1, 12'h10c, 32'h07, 2'b00},
         '{1, 12'h118, 32'h30, 2'b00}, '{0, 12'h118, 32'h30, 2'b00},
         '{1, 12'h0f0, 32'h00, 2'b10}, '{0, 12'h0f0, 32'h00, 2'b10},
         '{0, 12'h10c, 32'h07, 2'b00}};
      do_reset();
      @(negedge CLOCK);
      check({29'h0, MODE}, 32'h1);
      check({31'h0, DRIVE_REF}, 32'h0);
      @(posedge CLOCK);
      for (i = 0; i < 11; i++) begin
         if (rows[i].wr) begin
            axi_wr(rows[i].a, rows[i].d, rs);
         end else begin
            axi_rd(rows[i].a, rd, rs);
            if (rs === 2'b00) check(rd, rows[i].d);
         end
         check({30'h0, rs}, {30'h0, rows[i].resp});
      end
      strb <= 4'h0;
      axi_wr(`REG_CONTROL, 32'h3, rs);
      strb <= 4'hf;
      axi_rd(`REG_CONTROL, rd, rs);
      check(rd, 32'hf);
      $display("test registers done");
      do_reset();
      repeat (3) @(negedge CLOCK);
      check({29'h0, MODE}, 32'h5);
      check({31'h0, SEQ_RUN}, 32'h1);
      check({24'h0, SEQ_START}, 32'h30);
      $display("test resume done");
      @(posedge CLOCK);
      BUTTON <= 1'b1;
      wait_mode(3'h1, t1);
      wait_mode(3'h2, t2);
      check(t2 - t1, 5120);
      @(posedge CLOCK);
      BUTTON <= 1'b0;
      for (i = 0; i < 20000 && SEQ_RUN !== 1'b1; i++) @(negedge CLOCK);
      check({29'h0, MODE, SEQ_RUN, SEQ_START}, {29'h2, 1'b1, 8'h07});
      @(posedge CLOCK);
      axi_rd(12'h104, rd, rs);
      check(rd, 32'h2);
      seq_level <= 6'h20;
      for (i = 0; i < 3000 && SEQ_STEP !== 1'b1; i++) @(negedge CLOCK);
      check({31'h0, SEQ_STEP}, 32'h1);
      @(posedge CLOCK);
      axi_rd(`REG_STATUS, rd, rs);
      check(rd[23:8], 16'h1010);
      duty_run(16);
      code <= 8'h80;
      seq_level <= 6'h3f;
      duty_run(252);
      $display("test mode change done");
      // a good sample in mid-run must restart the low count
      code <= 8'hff;
      samples(12);
      code <= 8'h10;
      samples(1);
      code <= 8'hff;
      slow <= 1'b1;
      samples(31);
      axi_rd(`REG_STATUS, rd, rs);
      check({30'h0, rd[5:4]}, 32'h0);
      samples(1);
      axi_rd(`REG_STATUS, rd, rs);
      check({30'h0, rd[5:4]}, 32'h3);
      t1 = 0;
      for (i = 0; i < 2600; i++) begin
         @(negedge CLOCK);
         if (DRIVE_REF !== 1'b0 || ADC_START !== 1'b0 || SEQ_STEP !== 1'b0) t1++;
      end
      check(t1, 0);
      $display("test low battery done");
      close_out();
   end
endmodule
`default_nettype wire
